// file: hw/serws_pkg.sv
// shared constants, enums and state structs of the serial eeprom sequencer
package serws_pkg;

  // ==========================================================
  // link framing
  // ==========================================================
  localparam int ADDR_BITS = 16; // address field always received in full
  localparam int ARRAY_AW = 10; // default array of 1024 bytes
  localparam int PAGE_AW = 5; // in-page address bits
  localparam int PAGE_BYTES = 32; // bytes per programming page
  localparam logic [2:0] BIT_LAST = 3'h7; // last bit slot of a byte

  // ==========================================================
  // command opcodes, bit 3 is not compared
  // ==========================================================
  localparam logic [3:0] OPC_TOP = 4'h0; // upper nibble of every opcode
  localparam logic [2:0] OPC_READ = 3'h3; // array read
  localparam logic [2:0] OPC_WRITE = 3'h2; // array write
  localparam logic [2:0] OPC_SETWL = 3'h6; // set_write_latch_cmd
  localparam logic [2:0] OPC_STAT = 3'h5; // status_read_cmd

  // ==========================================================
  // status byte layout
  // ==========================================================
  localparam logic [7:0] STAT_BUSY = 8'hff; // all ones while programming
  localparam logic [7:0] STAT_IDLE = 8'h00; // base value when ready
  localparam int ST_WEL = 1; // write latch bit
  localparam int ST_BP_LO = 2; // low bit of protect level field

  // ==========================================================
  // block protection levels
  // ==========================================================
  localparam logic [1:0] BP_NONE = 2'h0; // nothing protected
  localparam logic [1:0] BP_QUARTER = 2'h1; // top quarter protected
  localparam logic [1:0] BP_HALF = 2'h2; // top half protected
  localparam logic [1:0] BP_ALL = 2'h3; // whole array protected

  // ==========================================================
  // programming time
  // ==========================================================
  localparam int CLK_KHZ = 10000; // core clock rate
  localparam int PROG_TIME_US = 5000; // self-timed cycle length
  localparam int PROG_CYCLES = (PROG_TIME_US * CLK_KHZ + 999) / 1000;

  // ==========================================================
  // state types
  // ==========================================================
  typedef enum logic [2:0] {
    PH_OPC, PH_ADDR, PH_RD, PH_WR, PH_STAT, PH_IGN
  } serws_phase_t;

  typedef enum logic [1:0] {
    PG_IDLE, PG_COPY, PG_WAIT
  } serws_prog_t;

  // per-selection state, cleared while chip select is high
  typedef struct packed {
    serws_phase_t phase; // where in the command we are
    logic [2:0] bitcnt; // bit slot inside current byte
    logic [6:0] sh; // bits of the byte being received
    logic is_wr; // command is an array write
    logic addr_lo; // high address byte already taken
    logic got_data; // at least one write byte loaded
    logic [ADDR_BITS-1:0] addr; // working byte address
    logic [7:0] tx; // byte being shifted out
  } serws_frame_t;

  // link-side state that outlives the selection
  typedef struct packed {
    logic busy_m; // busy, first sync stage
    logic busy_s; // busy, synced
    logic wel_m; // write latch, first sync stage
    logic wel_s; // write latch, synced
    logic [1:0] bp_m; // protect level, first sync stage
    logic [1:0] bp_s; // protect level, synced
    logic wel_tog; // toggles once per latch-set command
    logic wr_tag; // toggles at start of each accepted write
    logic armed; // last edge completed a write byte
    logic [ADDR_BITS-1:0] base; // write start address
    logic [PAGE_BYTES-1:0] mask; // page bytes loaded
  } serws_hold_t;

  // core-clock state
  typedef struct packed {
    serws_prog_t st; // programming sequencer
    logic busy; // programming cycle running
    logic wel; // write enable latch
    logic link_run; // releases link-side hold state
    logic cs_prev; // synced chip select, last cycle
    logic wel_seen; // last latch-set toggle seen
    logic last_tag; // last write tag handled
    logic [PAGE_AW-1:0] idx; // page byte being copied
    logic [31:0] cnt; // cycle counter of the wait
    logic [ADDR_BITS-1:0] base; // page being programmed
    logic [PAGE_BYTES-1:0] mask; // bytes to program
  } serws_core_t;

endpackage : serws_pkg

// file: hw/serws_sync.sv
// two flip-flop level synchroniser into the core clock
`timescale 1ns/1ps
module serws_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  // ==========================================================
  // synchroniser stages
  // ==========================================================
  logic [W-1:0] meta_r; // first stage, read only by second
  logic [W-1:0] sync_r; // second stage, safe to use

  // two stages, reset to the idle level
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end

  assign q_o = sync_r;

endmodule : serws_sync

// file: hw/serws_top.sv
// serial eeprom slave: command sequencing, array, page programming
`timescale 1ns/1ps
module serws_top #(
  parameter int ARRAY_AW = serws_pkg::ARRAY_AW,
  parameter int unsigned PROG_CYCLES = serws_pkg::PROG_CYCLES
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  input wire logic [1:0] bp_level_i,
  output logic busy_o,
  output logic wel_o
);

  // ==========================================================
  // storage
  // ==========================================================
  localparam int ARRAY_BYTES = 1 << ARRAY_AW; // array depth
  localparam int PW = serws_pkg::PAGE_AW; // short name for page bits
  localparam int AB = serws_pkg::ADDR_BITS; // short name for addr width
  localparam logic [31:0] WAIT_LAST = 32'(PROG_CYCLES - 1); // final count

  logic [7:0] mem [ARRAY_BYTES]; // array, written by core clock only
  logic [7:0] pagebuf [serws_pkg::PAGE_BYTES]; // written by link clock

  // ==========================================================
  // state
  // ==========================================================
  serws_pkg::serws_frame_t f_r; // selection state
  serws_pkg::serws_frame_t f_nxt;
  serws_pkg::serws_hold_t h_r; // lasting link state
  serws_pkg::serws_hold_t h_nxt;
  serws_pkg::serws_core_t c_r; // core clock state
  serws_pkg::serws_core_t c_nxt;

  logic so_r; // output bit, falling edge flop
  logic so_oe_r; // output enable, falling edge flop
  logic pb_we; // page buffer write strobe
  logic [PW-1:0] pb_idx; // page buffer slot
  logic [7:0] byte_in; // completed receive byte
  logic mem_we; // array write strobe
  logic [ARRAY_AW-1:0] mem_idx; // array write slot
  logic [7:0] mem_dat; // array write data
  logic cs_s; // chip select, synced to core
  logic wtog_s; // latch-set toggle, synced to core
  logic link_run; // hold state release

  // ==========================================================
  // helpers
  // ==========================================================
  // array byte at the don't-care-stripped address
  function automatic logic [7:0] rd_byte(input logic [AB-1:0] a);
    rd_byte = mem[a[ARRAY_AW-1:0]];
  endfunction : rd_byte

  // status byte as seen on the link
  function automatic logic [7:0] stat_byte(
    input logic busy,
    input logic wel,
    input logic [1:0] bp
  );
    logic [7:0] s;
    s = serws_pkg::STAT_IDLE;
    s[serws_pkg::ST_WEL] = wel;
    s[serws_pkg::ST_BP_LO +: 2] = bp;
    stat_byte = busy ? serws_pkg::STAT_BUSY : s;
  endfunction : stat_byte

  // protection test of one array address
  function automatic logic prot(
    input logic [AB-1:0] a,
    input logic [1:0] lvl
  );
    case (lvl)
      serws_pkg::BP_QUARTER: prot = &a[ARRAY_AW-1 -: 2];
      serws_pkg::BP_HALF: prot = a[ARRAY_AW-1];
      serws_pkg::BP_ALL: prot = 1'b1;
      default: prot = 1'b0; // level none
    endcase
  endfunction : prot

  // ==========================================================
  // link side: receive, decode, transmit
  // ==========================================================
  assign link_run = c_r.link_run;

  // next state on each rising serial clock edge
  always_comb begin
    f_nxt = f_r;
    h_nxt = h_r;
    pb_we = 1'b0;
    pb_idx = f_r.addr[PW-1:0];
    byte_in = {f_r.sh, si_i};
    // synchronisers of core state into the link clock
    h_nxt.busy_m = c_r.busy;
    h_nxt.busy_s = h_r.busy_m;
    h_nxt.wel_m = c_r.wel;
    h_nxt.wel_s = h_r.wel_m;
    h_nxt.bp_m = bp_level_i;
    h_nxt.bp_s = h_r.bp_m;
    h_nxt.armed = 1'b0; // any further edge disarms the write
    // shift in, msb first, sampled on the rising edge
    f_nxt.sh = byte_in[6:0];
    f_nxt.bitcnt = f_r.bitcnt + 3'h1;
    if (f_r.bitcnt == serws_pkg::BIT_LAST) begin
      case (f_r.phase)
        // opcode byte complete
        serws_pkg::PH_OPC: begin
          if (byte_in[7:4] != serws_pkg::OPC_TOP) begin
            f_nxt.phase = serws_pkg::PH_IGN; // unknown, sit out
          end else if (h_r.busy_s &&
                       byte_in[2:0] != serws_pkg::OPC_STAT) begin
            f_nxt.phase = serws_pkg::PH_IGN;
          end else begin
            case (byte_in[2:0])
              serws_pkg::OPC_READ: begin
                f_nxt.phase = serws_pkg::PH_ADDR;
                f_nxt.is_wr = 1'b0;
              end
              serws_pkg::OPC_WRITE: begin
                if (h_r.wel_s) begin
                  f_nxt.phase = serws_pkg::PH_ADDR;
                  f_nxt.is_wr = 1'b1;
                end else begin
                  f_nxt.phase = serws_pkg::PH_IGN;
                end
              end
              serws_pkg::OPC_SETWL: begin
                h_nxt.wel_tog = ~h_r.wel_tog; // event to core clock
                f_nxt.phase = serws_pkg::PH_IGN;
              end
              serws_pkg::OPC_STAT: begin
                f_nxt.phase = serws_pkg::PH_STAT;
                f_nxt.tx = stat_byte(h_r.busy_s, h_r.wel_s, h_r.bp_s);
              end
              default: begin
                f_nxt.phase = serws_pkg::PH_IGN; // not handled here
              end
            endcase
          end
        end
        // address bytes, high byte first
        serws_pkg::PH_ADDR: begin
          if (!f_r.addr_lo) begin
            f_nxt.addr = {byte_in, f_r.addr[7:0]};
            f_nxt.addr_lo = 1'b1;
          end else begin
            f_nxt.addr = {f_r.addr[AB-1:8], byte_in};
            if (f_r.is_wr) begin
              f_nxt.phase = serws_pkg::PH_WR;
              h_nxt.wr_tag = ~h_r.wr_tag; // marks a new write
              h_nxt.base = {f_r.addr[AB-1:8], byte_in};
            end else begin
              f_nxt.phase = serws_pkg::PH_RD;
              f_nxt.tx = rd_byte({f_r.addr[AB-1:8], byte_in});
            end
          end
        end
        // read data: serial input is not looked at
        serws_pkg::PH_RD: begin
          f_nxt.sh = f_r.sh;
          f_nxt.addr[ARRAY_AW-1:0] =
            ARRAY_AW'(f_r.addr[ARRAY_AW-1:0] + 1'b1);
          f_nxt.tx = rd_byte(f_nxt.addr);
        end
        // write data into the page buffer
        serws_pkg::PH_WR: begin
          pb_we = 1'b1;
          pb_idx = f_r.addr[PW-1:0];
          if (f_r.got_data) begin
            h_nxt.mask[f_r.addr[PW-1:0]] = 1'b1;
          end else begin
            h_nxt.mask = '0;
            h_nxt.mask[f_r.addr[PW-1:0]] = 1'b1;
          end
          f_nxt.got_data = 1'b1;
          f_nxt.addr[PW-1:0] = PW'(f_r.addr[PW-1:0] + 1'b1);
          h_nxt.armed = 1'b1;
        end
        // status byte repeats while selected
        serws_pkg::PH_STAT: begin
          f_nxt.sh = f_r.sh; // status ignores serial input
          f_nxt.tx = stat_byte(h_r.busy_s, h_r.wel_s, h_r.bp_s);
        end
        default: begin
          f_nxt.phase = serws_pkg::PH_IGN; // rest of selection ignored
        end
      endcase
    end
  end

  // selection state: cleared whenever chip select is high
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end

  // lasting link state, released by the core reset
  always_ff @(posedge sck_i or negedge link_run) begin
    if (!link_run) begin
      h_r <= '0;
    end else begin
      h_r <= h_nxt;
    end
  end

  // page buffer, one slot per rising edge at most
  always_ff @(posedge sck_i) begin
    if (pb_we) begin
      pagebuf[pb_idx] <= byte_in;
    end
  end

  // output bit changes on the falling edge, high-z when deselected
  always_ff @(negedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      so_r <= 1'b0;
      so_oe_r <= 1'b0;
    end else begin
      so_r <= f_r.tx[serws_pkg::BIT_LAST - f_r.bitcnt];
      so_oe_r <= (f_r.phase == serws_pkg::PH_RD) ||
                 (f_r.phase == serws_pkg::PH_STAT);
    end
  end

  assign so_o = so_r;
  assign so_oe_o = so_oe_r;

  // ==========================================================
  // core side: crossings
  // ==========================================================
  serws_sync #(
    .W(2),
    .RST_VAL(2'h2)
  ) u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i({cs_n_i, h_r.wel_tog}),
    .q_o({cs_s, wtog_s})
  );

  // ==========================================================
  // core side: latch and programming sequencer
  // ==========================================================
  // commit on select rising, copy page, then self-timed wait
  always_comb begin
    c_nxt = c_r;
    mem_we = 1'b0;
    mem_idx = c_r.base[ARRAY_AW-1:0];
    mem_dat = pagebuf[c_r.idx];
    c_nxt.link_run = 1'b1;
    c_nxt.cs_prev = cs_s;
    c_nxt.wel_seen = wtog_s;
    case (c_r.st)
      // wait for the end of a selection
      serws_pkg::PG_IDLE: begin
        if (cs_s && !c_r.cs_prev) begin
          c_nxt.last_tag = h_r.wr_tag;
          if (h_r.armed && (h_r.wr_tag != c_r.last_tag)) begin
            c_nxt.st = serws_pkg::PG_COPY;
            c_nxt.busy = 1'b1;
            c_nxt.idx = '0;
            c_nxt.base = h_r.base;
            c_nxt.mask = h_r.mask;
          end
        end
      end
      // copy loaded page bytes that are not protected
      serws_pkg::PG_COPY: begin
        mem_idx = ARRAY_AW'({c_r.base[AB-1:PW], c_r.idx});
        if (c_r.mask[c_r.idx] &&
            !prot({c_r.base[AB-1:PW], c_r.idx}, bp_level_i)) begin
          mem_we = 1'b1;
        end
        c_nxt.idx = PW'(c_r.idx + 1'b1);
        if (c_r.idx == PW'(serws_pkg::PAGE_BYTES - 1)) begin
          c_nxt.st = serws_pkg::PG_WAIT;
          c_nxt.cnt = '0;
        end
      end
      // self-timed remainder of the cycle
      serws_pkg::PG_WAIT: begin
        c_nxt.cnt = c_r.cnt + 32'h1;
        if (c_r.cnt >= WAIT_LAST) begin
          c_nxt.st = serws_pkg::PG_IDLE;
          c_nxt.busy = 1'b0;
          c_nxt.wel = 1'b0;
        end
      end
      default: begin
        c_nxt.st = serws_pkg::PG_IDLE; // recover
      end
    endcase
    // latch set after clear: a set in the same cycle wins
    if (wtog_s != c_r.wel_seen) begin
      c_nxt.wel = 1'b1;
    end
  end

  // core state register
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      c_r <= '0;
      c_r.cs_prev <= 1'b1; // select idles high, no false rise
    end else begin
      c_r <= c_nxt;
    end
  end

  // array write port
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      mem[mem_idx] <= mem_dat;
    end
  end

  assign busy_o = c_r.busy;
  assign wel_o = c_r.wel;

endmodule : serws_top

// file: verif/serws_assertions.sv
// concurrent checks on the serial eeprom sequencer ports
`timescale 1ns/1ps
module serws_chk #(
  parameter int unsigned PROG_CYCLES = 20
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic so_o,
  input wire logic so_oe_o,
  input wire logic [1:0] bp_level_i,
  input wire logic busy_o,
  input wire logic wel_o
);
  // ==========================================================
  // helper logic
  // ==========================================================
  logic [31:0] bcnt_r; // core cycles spent busy
  logic [7:0] nrise_r; // serial clock rises in this frame
  logic [7:0] opc_r; // opcode shifted in this frame

  // count busy cycles, cleared while ready
  always_ff @(posedge clk_i) begin
    if (!resetn_i || !busy_o) begin
      bcnt_r <= '0;
    end else begin
      bcnt_r <= bcnt_r + 32'h1;
    end
  end

  // frame position and opcode, cleared while deselected
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      nrise_r <= '0;
      opc_r <= '0;
    end else begin
      if (nrise_r != 8'hff) nrise_r <= nrise_r + 8'h1;
      if (nrise_r < 8'h08) opc_r <= {opc_r[6:0], si_i};
    end
  end

  // ==========================================================
  // core clock checks
  // ==========================================================
  chk_so_released: assert property (
    @(posedge clk_i) disable iff (!resetn_i) cs_n_i |-> !so_oe_o)
    else $error("serial output driven while deselected");
  chk_latch_at_end: assert property (
    @(posedge clk_i) disable iff (!resetn_i) $fell(busy_o) |-> !wel_o)
    else $error("latch still set after programming");
  chk_latch_only_end: assert property (
    @(posedge clk_i) disable iff (!resetn_i) $fell(wel_o) |-> $fell(busy_o))
    else $error("latch cleared outside programming end");
  chk_start_gated: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    $rose(busy_o) |-> $past(wel_o) && cs_n_i && $past(cs_n_i, 2))
    else $error("programming started without latch or select high");
  chk_prog_length: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    $fell(busy_o) |-> bcnt_r >= PROG_CYCLES)
    else $error("programming cycle too short");

  // ==========================================================
  // serial clock checks
  // ==========================================================
  chk_out_after_opc: assert property (
    @(posedge sck_i) disable iff (cs_n_i) so_oe_o |-> nrise_r >= 8'h08)
    else $error("output driven before opcode complete");
  chk_out_cmd_kind: assert property (
    @(posedge sck_i) disable iff (cs_n_i) so_oe_o |-> opc_r[7:4] == 4'h0
    && (opc_r[2:0] == serws_pkg::OPC_READ
    || opc_r[2:0] == serws_pkg::OPC_STAT))
    else $error("output driven for a non-reading opcode");
  chk_read_after_addr: assert property (
    @(posedge sck_i) disable iff (cs_n_i)
    so_oe_o && opc_r[2:0] != serws_pkg::OPC_STAT |-> nrise_r >= 8'h18)
    else $error("read data before full address");
  chk_busy_stat_only: assert property (
    @(posedge sck_i) disable iff (cs_n_i)
    so_oe_o && busy_o |-> opc_r[2:0] == serws_pkg::OPC_STAT)
    else $error("non-status answer while programming");
endmodule : serws_chk

bind serws_top serws_chk #(.PROG_CYCLES(PROG_CYCLES)) i_chk (
  .clk_i(clk_i), .resetn_i(resetn_i), .sck_i(sck_i), .cs_n_i(cs_n_i),
  .si_i(si_i), .so_o(so_o), .so_oe_o(so_oe_o), .bp_level_i(bp_level_i),
  .busy_o(busy_o), .wel_o(wel_o));

// file: verif/serws_host.sv
// spi master model that drives the eeprom link in mode 0
`timescale 1ns/1ps
module serws_host (
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  input wire logic so_i
);
  // ==========================================================
  // idle levels: clock still low, deselected
  // ==========================================================
  initial begin
    sck_o = 1'b0;
    si_o = 1'b0;
    #1 cs_n_o = 1'b1; // late rise clears the select-reset flops
  end

  // every command opens with a falling select
  task sel;
    #37 cs_n_o = 1'b0;
    #23;
  endtask : sel

  // shift nb bits msb first, take serial output at each rise
  task xb(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < nb; i++) begin
      si_o = tx[7 - i];
      #40 sck_o = 1'b1;
      rx = {rx[6:0], so_i};
      #40 sck_o = 1'b0;
    end
  endtask : xb

  // deselect in the low time after the last bit, then rest
  task desel;
    #10 cs_n_o = 1'b1;
    si_o = ~si_o;
    #500;
  endtask : desel
endmodule : serws_host

// file: verif/tb.sv
// self-checking bench of the serial eeprom sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  $display("Error %s expected %h seen %h", nm, e, g); n_errors++; end end
module tb;
  // ==========================================================
  // signals and rows
  // ==========================================================
  localparam int unsigned PROG = 20; // short programming wait
  logic clk_i; // core clock
  logic resetn_i; // core reset
  logic [1:0] bp_level_i; // protect level
  logic sck, cs_n, si, so_o, so_oe_o, busy_o, wel_o; // link and status
  wire logic so_w = so_oe_o ? so_o : ~so_o; // released shows inverse
  int n_errors = 0; // mismatches
  int n_checks = 0; // comparisons
  logic [7:0] rx, b0, b1; // bytes seen on the link
  typedef struct packed {
    logic [15:0] a; // read start address
    logic [7:0] e0; // byte at address
    logic [7:0] e1; // byte after it
  } serws_row_t;
  serws_row_t rows [4] = '{'{16'h0000, 8'h02, 8'h03},
    '{16'h801d, 8'h1f, 8'h20}, '{16'hfc1e, 8'h20, 8'h01},
    '{16'h0010, 8'h12, 8'h13}};

  serws_top #(.ARRAY_AW(10), .PROG_CYCLES(PROG)) i_dut (.clk_i(clk_i),
    .resetn_i(resetn_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
    .so_o(so_o), .so_oe_o(so_oe_o), .bp_level_i(bp_level_i),
    .busy_o(busy_o), .wel_o(wel_o));
  serws_host i_host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so_w));

  // core clock, 100 ns
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // ==========================================================
  // tasks
  // ==========================================================
  task end_sim;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  // core inputs change just after a rising edge
  task drv(input logic r, input logic [1:0] v);
    @(posedge clk_i);
    #2 resetn_i = r;
    bp_level_i = v;
  endtask : drv

  // one-byte command frame
  task cmd(input logic [7:0] op);
    i_host.sel;
    i_host.xb(op, 8, rx);
    i_host.desel;
  endtask : cmd

  // write n bytes from dv upward, last one cut to nb bits
  task wr(input logic [15:0] a, input logic [7:0] dv, input int n,
          input int nb);
    i_host.sel;
    i_host.xb(8'h02, 8, rx);
    i_host.xb(a[15:8], 8, rx);
    i_host.xb(a[7:0], 8, rx);
    for (int i = 0; i < n; i++) i_host.xb(dv + 8'(i), i == n-1 ? nb : 8, rx);
    i_host.desel;
  endtask : wr

  // read two bytes, junk on serial input meanwhile
  task rd2(input logic [15:0] a);
    i_host.sel;
    i_host.xb(8'h03, 8, rx);
    i_host.xb(a[15:8], 8, rx);
    i_host.xb(a[7:0], 8, rx);
    i_host.xb(8'h02, 8, b0);
    i_host.xb(8'h06, 8, b1);
    i_host.desel;
  endtask : rd2

  // status read frame
  task stat;
    i_host.sel;
    i_host.xb(8'h05, 8, rx);
    i_host.xb(8'hc3, 8, rx);
    i_host.desel;
  endtask : stat

  // bounded wait for the end of programming
  task idle;
    for (int k = 0; k < 3000 && busy_o !== 1'b0; k++) @(posedge clk_i);
    `CHK("busy_o", 1'b0, busy_o)
  endtask : idle

  // watchdog cuts a hang short
  initial begin
    #3000000;
    n_errors++;
    $display("Error watchdog expected end seen timeout");
    end_sim;
  end

  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    resetn_i = 1'b0;
    bp_level_i = 2'h0;
    repeat (7) @(posedge clk_i);
    #2 `CHK("wel_o", 1'b0, wel_o)
    `CHK("busy_o", 1'b0, busy_o)
    `CHK("so_oe_o", 1'b0, so_oe_o)
    drv(1'b1, 2'h0);
    repeat (4) @(posedge clk_i);
    cmd(8'h0e);
    `CHK("wel_o", 1'b1, wel_o)
    for (int lv = 0; lv < 4; lv++) begin
      drv(1'b1, 2'(lv));
      stat;
      `CHK("status", {4'h0, 2'(lv), 2'h2}, rx)
    end
    drv(1'b1, 2'h0);
    $display("test latch and status done");
    wr(16'hfc1e, 8'h00, 33, 8);
    `CHK("busy_o", 1'b1, busy_o)
    stat;
    `CHK("busy status", 8'hff, rx)
    i_host.sel;
    i_host.xb(8'h03, 8, rx);
    i_host.xb(8'h00, 8, rx);
    i_host.xb(8'h00, 8, rx);
    i_host.xb(8'h00, 8, rx);
    `CHK("so_oe_o", 1'b0, so_oe_o)
    i_host.desel;
    idle;
    `CHK("wel_o", 1'b0, wel_o)
    stat;
    `CHK("ready status", 8'h00, rx)
    $display("test page write done");
    for (int r = 0; r < 4; r++) begin
      rd2(rows[r].a);
      `CHK("first byte", rows[r].e0, b0)
      `CHK("next byte", rows[r].e1, b1)
    end
    `CHK("wel_o", 1'b0, wel_o)
    $display("test read rows done");
    cmd(8'h06);
    wr(16'h03ff, 8'ha5, 1, 8);
    idle;
    for (int lv = 1; lv < 4; lv++) begin
      drv(1'b1, 2'(lv));
      cmd(8'h06);
      wr(16'h03ff, 8'(lv), 1, 8);
      idle;
    end
    drv(1'b1, 2'h0);
    rd2(16'h03ff);
    `CHK("top byte", 8'ha5, b0)
    `CHK("wrapped byte", 8'h02, b1)
    $display("test protect and wrap done");
    drv(1'b0, 2'h0);
    repeat (7) @(posedge clk_i);
    #2 `CHK("wel_o", 1'b0, wel_o)
    drv(1'b1, 2'h0);
    repeat (4) @(posedge clk_i);
    wr(16'h03ff, 8'h77, 1, 8);
    `CHK("busy_o", 1'b0, busy_o)
    cmd(8'h06);
    wr(16'h03ff, 8'h77, 1, 7);
    `CHK("busy_o", 1'b0, busy_o)
    rd2(16'h03ff);
    `CHK("kept byte", 8'ha5, b0)
    $display("test discarded writes done");
    end_sim;
  end
endmodule : tb
